//--- logic/acp_pkg.sv
// Shared constants and types for the ATA channel port
package acp_pkg;
  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 3;
  localparam int BE_W    = 4;
  localparam int CNT_W   = 8;
  localparam int PRES_W  = 8;
  localparam int CTL_W   = 4;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PS       = 5000;
  localparam int PRES_DLY_NS  = 1000;
  localparam int PRES_CYC     =
    (PRES_DLY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [PRES_W-1:0] PRES_LAST = PRES_W'(PRES_CYC - 1);

  // ************************************************************
  // Ultra DMA CRC
  // ************************************************************
  localparam logic [DATA_W-1:0] CRC_INIT = 16'h4abf;
  localparam logic [DATA_W-1:0] CRC_POLY = 16'h1021;

  // ************************************************************
  // Synchronised control and data inputs, bit positions
  // ************************************************************
  localparam int CI_CABLE = 0;
  localparam int CI_DMARQ = 1;
  localparam int CI_IRQ   = 2;
  localparam int CI_RDY   = 3;
  localparam int PRES_BIT = 7;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_P_SET,
    ST_P_ACT,
    ST_P_REC,
    ST_D_ACK,
    ST_D_GAP,
    ST_D_ACT,
    ST_D_REC,
    ST_D_END,
    ST_U_RUN,
    ST_U_STOP,
    ST_U_CRC,
    ST_U_END
  } acp_state_t;
endpackage

//--- logic/acp_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module acp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Asynchronous input and settled copy
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } acp_sync_regs_t;

  acp_sync_regs_t q;
  acp_sync_regs_t d;

  // Stage one feeds stage two only; change counts once 2 and 3 agree
  always_comb begin
    d    = q;
    d.s1 = i_d;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.q  = (q.s2 & ~(q.s2 ^ q.s3)) | (q.q & (q.s2 ^ q.s3));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_q = q.q;
endmodule

//--- logic/acp_crc.sv
// Ultra DMA burst CRC accumulator, one word per enable
`timescale 1ns/1ps
module acp_crc (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // Control and data
  input  wire logic                      i_clear,
  input  wire logic                      i_en,
  input  wire logic [acp_pkg::DATA_W-1:0] i_word,
  output logic      [acp_pkg::DATA_W-1:0] o_crc
);
  typedef struct packed {
    logic [acp_pkg::DATA_W-1:0] crc;
  } acp_crc_regs_t;

  acp_crc_regs_t q;
  acp_crc_regs_t d;

  function automatic logic [acp_pkg::DATA_W-1:0] step(
    input logic [acp_pkg::DATA_W-1:0] c,
    input logic [acp_pkg::DATA_W-1:0] w
  );
    logic [acp_pkg::DATA_W-1:0] r;
    logic                       fb;
    r = c;
    for (int i = acp_pkg::DATA_W - 1; i >= 0; i--) begin
      fb = r[acp_pkg::DATA_W-1] ^ w[i];
      r  = {r[acp_pkg::DATA_W-2:0], 1'b0};
      if (fb) begin
        r = r ^ acp_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  always_comb begin
    d = q;
    if (i_clear) begin
      d.crc = acp_pkg::CRC_INIT;
    end else if (i_en) begin
      d.crc = step(q.crc, i_word);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q.crc <= acp_pkg::CRC_INIT;
    end else begin
      q <= d;
    end
  end

  assign o_crc = q.crc;
endmodule

//--- logic/acp_chan.sv
// Host-end signalling for one parallel ATA channel
`timescale 1ns/1ps
// Overview of operation
// - Sixteen-bit data bus, low byte bits 7:0
// - Data bus driven from write strobe to end of recovery, and for Ultra CRC
// - Ultra DMA data valid on every strobe edge
// - Data bit 7 senses drive presence after reset
// - Two active-low command/control block selects
// - DMA acknowledge negates both selects, full words
// - Register address from address and byte enables
// - Read strobe idles high, pulses low
// - Write strobe idles high, pulses low
// - Read strobe is HSTROBE or host ready
// - Write strobe acts as STOP in Ultra
// - Cable input low 40, high 80 conductor
// - DMA acknowledge answers drive DMA request
// - CRC sent at burst end under acknowledge
// - Drive interrupt drives host interrupt output
// - PIO cycle held while drive ready low
// - Ready line is DSTROBE or drive ready
// - Drive reset follows reset or software bit
module acp_chan #(
  parameter int CNT_W = acp_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  // PIO requests
  input  wire logic                       i_req,
  input  wire logic                       i_req_wr,
  input  wire logic                       i_req_ctl,
  input  wire logic [acp_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [acp_pkg::BE_W-1:0]   i_req_be,
  input  wire logic [acp_pkg::DATA_W-1:0] i_req_wdata,
  // Timing and control
  input  wire logic [CNT_W-1:0]           i_pio_act,
  input  wire logic [CNT_W-1:0]           i_pio_rec,
  input  wire logic                       i_sw_drive_reset,
  // DMA requests
  input  wire logic                       i_dma_en,
  input  wire logic                       i_dma_wr,
  input  wire logic                       i_dma_ultra,
  input  wire logic [acp_pkg::DATA_W-1:0] i_dma_wdata,
  input  wire logic                       i_dma_wvalid,
  // Results and status
  output logic                            o_busy,
  output logic                            o_done,
  output logic      [acp_pkg::DATA_W-1:0] o_rdata,
  output logic      [acp_pkg::DATA_W-1:0] o_dma_rdata,
  output logic                            o_dma_rvalid,
  output logic                            o_dma_wtake,
  output logic                            o_cable_80,
  output logic                            o_dev_absent,
  // Channel pins
  input  wire logic [acp_pkg::DATA_W-1:0] i_chan_data_bus,
  output logic      [acp_pkg::DATA_W-1:0] o_chan_data_bus,
  output logic                            o_chan_data_bus_oe,
  output logic                            o_chan_cmd_block_sel_n,
  output logic                            o_chan_ctl_block_sel_n,
  output logic      [acp_pkg::ADDR_W-1:0] o_chan_reg_addr,
  output logic                            o_chan_read_strobe_n,
  output logic                            o_chan_write_strobe_n,
  output logic                            o_chan_dma_ack_n,
  output logic                            o_chan_drive_reset_n,
  input  wire logic                       i_chan_cable_type_n,
  input  wire logic                       i_chan_dma_req,
  input  wire logic                       i_chan_drive_irq,
  input  wire logic                       i_chan_drive_ready,
  // Host interrupt, open drain
  output logic                            o_host_irq_n,
  output logic                            o_host_irq_oe
);
  typedef struct packed {
    acp_pkg::acp_state_t          st;
    logic [CNT_W-1:0]             cnt;
    logic                         wr;
    logic                         ultra;
    logic                         pend;
    logic                         rdy_last;
    logic [acp_pkg::PRES_W-1:0]   pres_cnt;
    logic                         pres_done;
    logic                         absent;
    logic                         busy;
    logic                         done;
    logic [acp_pkg::DATA_W-1:0]   rdata;
    logic [acp_pkg::DATA_W-1:0]   dma_rdata;
    logic                         rvalid;
    logic                         wtake;
    logic                         cable80;
    logic [acp_pkg::DATA_W-1:0]   dd;
    logic                         dd_oe;
    logic                         cs0_n;
    logic                         cs1_n;
    logic [acp_pkg::ADDR_W-1:0]   da;
    logic                         rd_n;
    logic                         wr_n;
    logic                         ack_n;
    logic                         rst_n;
    logic                         irq_n;
    logic                         irq_oe;
  } acp_chan_regs_t;

  acp_chan_regs_t q;
  acp_chan_regs_t d;

  logic [acp_pkg::DATA_W-1:0] dd_s;
  logic [acp_pkg::CTL_W-1:0]  ctl_s;
  logic [acp_pkg::DATA_W-1:0] crc_val;
  logic [acp_pkg::DATA_W-1:0] crc_word;
  logic                       crc_clr;
  logic                       crc_en;
  logic                       cable_s;
  logic                       dmarq_s;
  logic                       irq_s;
  logic                       rdy_s;
  logic                       cnt_z;
  logic                       dstb_edge;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Lowest enabled lane picks the byte register inside the block
  function automatic logic [acp_pkg::ADDR_W-1:0] reg_addr(
    input logic [acp_pkg::ADDR_W-1:0] a,
    input logic [acp_pkg::BE_W-1:0]   be
  );
    logic [1:0] lane;
    lane = 2'h0;
    if (be[0]) begin
      lane = 2'h0;
    end else if (be[1]) begin
      lane = 2'h1;
    end else if (be[2]) begin
      lane = 2'h2;
    end else if (be[3]) begin
      lane = 2'h3;
    end
    return {a[2], lane};
  endfunction

  // Load value for a count of n cycles, never below one
  function automatic logic [CNT_W-1:0] ld(input logic [CNT_W-1:0] n);
    return (n == '0) ? '0 : n - 1'b1;
  endfunction

  // ************************************************************
  // Input synchronisers and CRC
  // ************************************************************
  acp_sync #(.W(acp_pkg::DATA_W)) u_dd_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_chan_data_bus),
    .o_q   (dd_s)
  );

  acp_sync #(.W(acp_pkg::CTL_W)) u_ctl_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_chan_drive_ready, i_chan_drive_irq,
             i_chan_dma_req, i_chan_cable_type_n}),
    .o_q   (ctl_s)
  );

  acp_crc u_crc (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_clear (crc_clr),
    .i_en    (crc_en),
    .i_word  (crc_word),
    .o_crc   (crc_val)
  );

  assign cable_s   = ctl_s[acp_pkg::CI_CABLE];
  assign dmarq_s   = ctl_s[acp_pkg::CI_DMARQ];
  assign irq_s     = ctl_s[acp_pkg::CI_IRQ];
  assign rdy_s     = ctl_s[acp_pkg::CI_RDY];
  assign cnt_z     = (q.cnt == '0);
  assign dstb_edge = (rdy_s != q.rdy_last);

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    d          = q;
    d.done     = 1'b0;
    d.rvalid   = 1'b0;
    d.wtake    = 1'b0;
    d.rdy_last = rdy_s;
    crc_clr    = 1'b0;
    crc_en     = 1'b0;
    crc_word   = q.dd;
    d.irq_n    = ~irq_s;
    d.irq_oe   = irq_s;
    d.cable80  = cable_s;
    d.rst_n    = ~i_sw_drive_reset;
    if (!cnt_z) begin
      d.cnt = q.cnt - 1'b1;
    end
    // Pull-down leaves bit 7 low when no drive answers
    if (!q.pres_done) begin
      if (q.pres_cnt == acp_pkg::PRES_LAST) begin
        d.pres_done = 1'b1;
        d.absent    = ~dd_s[acp_pkg::PRES_BIT];
      end else begin
        d.pres_cnt = q.pres_cnt + 1'b1;
      end
    end
    unique case (q.st)
      acp_pkg::ST_IDLE: begin
        if (i_req && q.pres_done) begin
          d.st    = acp_pkg::ST_P_SET;
          d.wr    = i_req_wr;
          d.da    = reg_addr(i_req_addr, i_req_be);
          d.cs0_n = i_req_ctl;
          d.cs1_n = ~i_req_ctl;
          d.dd    = i_req_wdata;
        end else if (i_dma_en && dmarq_s && q.pres_done) begin
          d.st    = acp_pkg::ST_D_ACK;
          d.ack_n = 1'b0;
          d.cs0_n = 1'b1;
          d.cs1_n = 1'b1;
          d.wr    = i_dma_wr;
          d.ultra = i_dma_ultra;
          d.pend  = 1'b0;
          d.cnt   = ld(i_pio_rec);
          crc_clr = 1'b1;
        end
      end
      acp_pkg::ST_P_SET: begin
        d.st  = acp_pkg::ST_P_ACT;
        d.cnt = ld(i_pio_act);
        if (q.wr) begin
          d.wr_n  = 1'b0;
          d.dd_oe = 1'b1;
        end else begin
          d.rd_n = 1'b0;
        end
      end
      acp_pkg::ST_P_ACT: begin
        // Stretch the strobe while the drive holds ready low
        if (cnt_z && rdy_s) begin
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          d.st   = acp_pkg::ST_P_REC;
          d.cnt  = ld(i_pio_rec);
          if (!q.wr) begin
            d.rdata = dd_s;
          end
        end
      end
      acp_pkg::ST_P_REC: begin
        if (cnt_z) begin
          d.dd_oe = 1'b0;
          d.cs0_n = 1'b1;
          d.cs1_n = 1'b1;
          d.done  = 1'b1;
          d.st    = acp_pkg::ST_IDLE;
        end
      end
      acp_pkg::ST_D_ACK: begin
        if (cnt_z) begin
          if (q.ultra) begin
            d.st   = acp_pkg::ST_U_RUN;
            d.wr_n = 1'b0;
            d.rd_n = q.wr;
          end else begin
            d.st = acp_pkg::ST_D_GAP;
          end
        end
      end
      acp_pkg::ST_D_GAP: begin
        if (!i_dma_en || !dmarq_s) begin
          d.st = acp_pkg::ST_D_END;
        end else if (!q.wr || i_dma_wvalid) begin
          d.st  = acp_pkg::ST_D_ACT;
          d.cnt = ld(i_pio_act);
          if (q.wr) begin
            d.dd    = i_dma_wdata;
            d.dd_oe = 1'b1;
            d.wr_n  = 1'b0;
            d.wtake = 1'b1;
          end else begin
            d.rd_n = 1'b0;
          end
        end
      end
      acp_pkg::ST_D_ACT: begin
        if (cnt_z) begin
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          d.st   = acp_pkg::ST_D_REC;
          d.cnt  = ld(i_pio_rec);
          if (!q.wr) begin
            d.dma_rdata = dd_s;
            d.rvalid    = 1'b1;
          end
        end
      end
      acp_pkg::ST_D_REC: begin
        if (cnt_z) begin
          d.dd_oe = 1'b0;
          d.st    = acp_pkg::ST_D_GAP;
        end
      end
      acp_pkg::ST_D_END: begin
        d.ack_n = 1'b1;
        d.done  = 1'b1;
        d.st    = acp_pkg::ST_IDLE;
      end
      acp_pkg::ST_U_RUN: begin
        if ((!i_dma_en || !dmarq_s) && !q.pend) begin
          d.st   = acp_pkg::ST_U_STOP;
          d.wr_n = 1'b1;
          d.rd_n = 1'b1;
          d.cnt  = ld(i_pio_rec);
        end else if (q.wr) begin
          // Data set up first, the strobe toggles a count later
          if (q.pend && cnt_z) begin
            d.rd_n = ~q.rd_n;
            d.pend = 1'b0;
            d.cnt  = ld(i_pio_rec);
            crc_en = 1'b1;
          end else if (!q.pend && cnt_z && !rdy_s
                       && i_dma_wvalid) begin
            d.dd    = i_dma_wdata;
            d.dd_oe = 1'b1;
            d.wtake = 1'b1;
            d.pend  = 1'b1;
            d.cnt   = ld(i_pio_act);
          end
        end else if (dstb_edge) begin
          d.dma_rdata = dd_s;
          d.rvalid    = 1'b1;
          crc_en      = 1'b1;
          crc_word    = dd_s;
        end
      end
      acp_pkg::ST_U_STOP: begin
        if (cnt_z) begin
          d.dd    = crc_val;
          d.dd_oe = 1'b1;
          d.st    = acp_pkg::ST_U_CRC;
          d.cnt   = ld(i_pio_rec);
        end
      end
      acp_pkg::ST_U_CRC: begin
        if (cnt_z) begin
          d.ack_n = 1'b1;
          d.st    = acp_pkg::ST_U_END;
          d.cnt   = ld(i_pio_rec);
        end
      end
      acp_pkg::ST_U_END: begin
        if (cnt_z) begin
          d.dd_oe = 1'b0;
          d.done  = 1'b1;
          d.st    = acp_pkg::ST_IDLE;
        end
      end
    endcase
    d.busy = (d.st != acp_pkg::ST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q       <= '0;
      q.cs0_n <= 1'b1;
      q.cs1_n <= 1'b1;
      q.rd_n  <= 1'b1;
      q.wr_n  <= 1'b1;
      q.ack_n <= 1'b1;
      q.irq_n <= 1'b1;
      q.rst_n <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_busy                 = q.busy;
  assign o_done                 = q.done;
  assign o_rdata                = q.rdata;
  assign o_dma_rdata            = q.dma_rdata;
  assign o_dma_rvalid           = q.rvalid;
  assign o_dma_wtake            = q.wtake;
  assign o_cable_80             = q.cable80;
  assign o_dev_absent           = q.absent;
  assign o_chan_data_bus        = q.dd;
  assign o_chan_data_bus_oe     = q.dd_oe;
  assign o_chan_cmd_block_sel_n = q.cs0_n;
  assign o_chan_ctl_block_sel_n = q.cs1_n;
  assign o_chan_reg_addr        = q.da;
  assign o_chan_read_strobe_n   = q.rd_n;
  assign o_chan_write_strobe_n  = q.wr_n;
  assign o_chan_dma_ack_n       = q.ack_n;
  assign o_chan_drive_reset_n   = q.rst_n;
  assign o_host_irq_n           = q.irq_n;
  assign o_host_irq_oe          = q.irq_oe;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  chk_ack_no_select: assert property (
    !o_chan_dma_ack_n |-> o_chan_cmd_block_sel_n && o_chan_ctl_block_sel_n)
    else $error("select active under DMA acknowledge");
  chk_bus_drive_win: assert property (
    $rose(o_chan_data_bus_oe) |->
      !o_chan_write_strobe_n || !o_chan_dma_ack_n)
    else $error("data bus driven outside write window");
  chk_idle_strobes: assert property (
    q.st == acp_pkg::ST_IDLE |->
      o_chan_read_strobe_n && o_chan_write_strobe_n)
    else $error("strobe active while idle");
  chk_ready_hold: assert property (
    q.st == acp_pkg::ST_P_ACT && !rdy_s |=>
      q.st == acp_pkg::ST_P_ACT && !o_done)
    else $error("PIO cycle ended while ready low");
  chk_reg_addr_dec: assert property (
    q.st == acp_pkg::ST_IDLE && i_req && q.pres_done |=>
      o_chan_reg_addr == reg_addr($past(i_req_addr), $past(i_req_be)))
    else $error("register address decode wrong");
  chk_cable_type: assert property (
    $changed(cable_s) |=> o_cable_80 == $past(cable_s))
    else $error("cable type not followed");
  chk_irq_forward: assert property (
    irq_s |-> ##1 (!o_host_irq_n && o_host_irq_oe))
    else $error("drive interrupt not forwarded");
  chk_ack_on_req: assert property (
    q.st == acp_pkg::ST_IDLE && !i_req && i_dma_en && dmarq_s
      && q.pres_done |=> !o_chan_dma_ack_n ##1 !o_chan_dma_ack_n)
    else $error("no acknowledge for DMA request");
  chk_crc_at_end: assert property (
    $rose(o_chan_dma_ack_n) && q.ultra |->
      o_chan_data_bus_oe && o_chan_data_bus == $past(o_chan_data_bus))
    else $error("CRC not on bus at acknowledge release");
  chk_udma_roles: assert property (
    q.st == acp_pkg::ST_U_RUN && !q.wr |->
      !o_chan_read_strobe_n && !o_chan_write_strobe_n)
    else $error("host ready or STOP wrong in Ultra read");
  chk_drive_reset: assert property (
    i_sw_drive_reset |=> !o_chan_drive_reset_n)
    else $error("drive reset not asserted");

  cov_pio_read: cover property (
    q.st == acp_pkg::ST_P_REC && !q.wr ##1 o_done);
  cov_mw_write: cover property (
    q.st == acp_pkg::ST_D_ACT && q.wr ##1 q.st == acp_pkg::ST_D_REC);
  cov_udma_crc: cover property (
    q.st == acp_pkg::ST_U_CRC ##1 q.st == acp_pkg::ST_U_END);
endmodule

//--- verification/acp_drive_model.sv
// Drive-side model of the far end of the ATA channel
`timescale 1ns/1ps
module acp_drive_model #(
  parameter logic PRESENT = 1'b1
) (
  // Clock
  input  wire logic        i_clk,
  // Host pins seen by the drive
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_ack_n,
  input  wire logic        i_oe,
  input  wire logic [15:0] i_hdata,
  input  wire logic [2:0]  i_addr,
  // Resolved bus and last written word
  output logic      [15:0] o_bus,
  output logic      [15:0] o_wdata
);
  logic [15:0] idle_q = 16'h0000;
  logic        wr_q   = 1'b1;

  // Floating lines wander so a stale value never looks valid
  always @(posedge i_clk) begin
    idle_q <= ~idle_q;
    wr_q   <= i_wr_n;
    if (i_wr_n && !wr_q) begin
      o_wdata <= o_bus;
    end
  end

  always_comb begin
    if (i_oe) begin
      o_bus = i_hdata;
    end else if (!i_rd_n) begin
      o_bus = i_ack_n ? (16'hc3a0 | 16'(i_addr)) : 16'h5a5a;
    end else begin
      o_bus = {idle_q[15:8], PRESENT, idle_q[6:0]};
    end
  end
endmodule

//--- verification/acp_chan_test.sv
// Self-checking bench for the ATA channel host port
`timescale 1ns/1ps
module acp_chan_test;
  localparam int ACT = 6;
  logic        clk = 1'b0;
  logic        rst, req, wr, ctl, swr, den, dreq, irq, cbl, rdy;
  logic        done, rvalid, cable80, absent, oe, cmd_n, ctl_n;
  logic        rd_n, wr_n, ack_n, drst_n, hirq_n, hirq_oe;
  logic        busy, wtake, dwr, ult;
  logic [2:0]  addr, regaddr;
  logic [3:0]  be;
  logic [7:0]  act_v, rec_v;
  logic [15:0] wd, rdata, drdata, hdata, bus, wdat;
  int          errors, cmp_count;

  always #2.5 clk = ~clk;

  acp_chan u_dut (
    .i_clk(clk), .i_rst(rst), .i_req(req), .i_req_wr(wr),
    .i_req_ctl(ctl), .i_req_addr(addr), .i_req_be(be),
    .i_req_wdata(wd), .i_pio_act(act_v), .i_pio_rec(rec_v),
    .i_sw_drive_reset(swr), .i_dma_en(den), .i_dma_wr(dwr),
    .i_dma_ultra(ult), .i_dma_wdata(16'h3c96), .i_dma_wvalid(dwr),
    .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_dma_rdata(drdata),
    .o_dma_rvalid(rvalid), .o_dma_wtake(wtake), .o_cable_80(cable80),
    .o_dev_absent(absent), .i_chan_data_bus(bus),
    .o_chan_data_bus(hdata), .o_chan_data_bus_oe(oe),
    .o_chan_cmd_block_sel_n(cmd_n), .o_chan_ctl_block_sel_n(ctl_n),
    .o_chan_reg_addr(regaddr), .o_chan_read_strobe_n(rd_n),
    .o_chan_write_strobe_n(wr_n), .o_chan_dma_ack_n(ack_n),
    .o_chan_drive_reset_n(drst_n), .i_chan_cable_type_n(cbl),
    .i_chan_dma_req(dreq), .i_chan_drive_irq(irq),
    .i_chan_drive_ready(rdy), .o_host_irq_n(hirq_n),
    .o_host_irq_oe(hirq_oe)
  );

  acp_drive_model u_drv (
    .i_clk(clk), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_ack_n(ack_n),
    .i_oe(oe), .i_hdata(hdata), .i_addr(regaddr), .o_bus(bus),
    .o_wdata(wdat)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Ultra DMA CRC, one word msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? acp_pkg::CRC_POLY : 16'h0);
    return c;
  endfunction

  task automatic finish_test;
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One PIO cycle; the drive holds ready low for stall cycles after the first strobe-low cycle
  task automatic pio(input logic w, input logic c, input logic [3:0] b,
                     input logic [2:0] ea, input int stall);
    int lo;
    lo = 0;
    req = 1'b1;
    wr = w;
    ctl = c;
    be = b;
    addr = ea;
    wd = 16'h9e00 | 16'(b);
    tick(1);
    req = 1'b0;
    for (int i = 0; i < 300 && done !== 1'b1; i++) begin
      rdy = !(lo > 0 && lo <= stall);
      if ((w ? wr_n : rd_n) === 1'b0) begin
        lo++;
        check(regaddr, ea);
        check({cmd_n, ctl_n}, c ? 2'b10 : 2'b01);
        check(oe, w);
        check(w ? rd_n : wr_n, 1'b1);
      end
      tick(1);
    end
    check(done, 1'b1);
    check(stall > 0 ? lo >= stall + 3 : lo == ACT, 1'b1);
    check(w ? wdat : rdata, w ? wd : (16'hc3a0 | 16'(ea)));
    tick(1);
  endtask

  task automatic pins;
    for (int v = 0; v < 3; v++) begin
      cbl = v[0];
      irq = v[0];
      swr = v[0];
      tick(8);
      check(cable80, v[0]);
      check({hirq_n, hirq_oe}, {~v[0], v[0]});
      check(drst_n, !v[0]);
    end
  endtask

  task automatic dma_rd;
    den = 1'b1;
    dreq = 1'b1;
    for (int i = 0; i < 40 && ack_n !== 1'b0; i++) tick(1);
    check(ack_n, 1'b0);
    for (int i = 0; i < 80 && rvalid !== 1'b1; i++) begin
      check({cmd_n, ctl_n, oe}, 3'b110);
      tick(1);
    end
    check(drdata, 16'h5a5a);
    dreq = 1'b0;
    for (int i = 0; i < 80 && done !== 1'b1; i++) tick(1);
    check(done, 1'b1);
    den = 1'b0;
    tick(1);
    check(ack_n, 1'b1);
  endtask

  // One multiword write word, request dropped as it is taken
  task automatic dma_wr;
    {dwr, den, dreq} = 3'b111;
    for (int i = 0; i < 40 && wtake !== 1'b1; i++) tick(1);
    check({busy, ack_n, cmd_n, ctl_n}, 4'b1011);
    dreq = 1'b0;
    for (int i = 0; i < 80 && done !== 1'b1; i++) begin
      if (wr_n === 1'b0) check(oe, 1'b1);
      tick(1);
    end
    check(done, 1'b1);
    check(wdat, 16'h3c96);
    {dwr, den} = 2'b00;
    tick(1);
  endtask

  // Ultra read: drive toggles the strobe four times, then CRC
  task automatic udma_rd;
    logic [15:0] crc;
    int          n;
    crc = acp_pkg::CRC_INIT;
    n = 0;
    {ult, den, dreq} = 3'b111;
    for (int i = 0; i < 40 && rd_n !== 1'b0; i++) tick(1);
    check({ack_n, rd_n, wr_n}, 3'b000);
    for (int e = 0; e < 4; e++) begin
      rdy = ~rdy;
      for (int i = 0; i < 6; i++) begin
        if (rvalid === 1'b1) begin
          n++;
          check(drdata, 16'h5a5a);
          crc = crc_step(crc, 16'h5a5a);
        end
        tick(1);
      end
    end
    check(n, 4);
    dreq = 1'b0;
    for (int i = 0; i < 40 && oe !== 1'b1; i++) tick(1);
    check({ack_n, rd_n, wr_n}, 3'b011);
    check(hdata, crc);
    for (int i = 0; i < 40 && done !== 1'b1; i++) tick(1);
    check({done, ack_n}, 2'b11);
    {ult, den} = 2'b00;
    tick(1);
  endtask

  initial begin
    {rst, req, wr, ctl, swr, den, dreq, irq, cbl, dwr, ult} = 11'h400;
    rdy = 1'b1;
    addr = 3'b000;
    be = 4'b0000;
    wd = 16'h0000;
    act_v = 8'h06;
    rec_v = 8'h02;
    errors = 0;
    cmp_count = 0;
    tick(20);
    check({drst_n, rd_n, wr_n, cmd_n, ctl_n, ack_n}, 6'h1f);
    rst = 1'b0;
    tick(205);
    check(absent, 1'b0);
    for (int k = 0; k < 4; k++)
      pio(k[0], k[1], 4'b1000 | (4'b0001 << k), {k[0], k[1:0]}, 0);
    pio(1'b1, 1'b0, 4'b0100, 3'b010, 10);
    pio(1'b0, 1'b0, 4'b0001, 3'b000, 10);
    pins();
    dma_rd();
    dma_wr();
    udma_rd();
    finish_test();
  end

  initial begin
    #200000;
    errors++;
    finish_test();
  end
endmodule
